/* File: sscs_map.vh */
// Constants for the sensor SPI configuration slave
`ifndef SSCS_MAP_VH
`define SSCS_MAP_VH
`define SSCS_ADDR_W 16
`define SSCS_DATA_W 16
`define SSCS_CLK_MHZ 25
`define SSCS_FETCH_CFG_NS 1500
`define SSCS_FETCH_RUN_NS 4500
`define SSCS_FETCH_CFG_CYC ((`SSCS_FETCH_CFG_NS * `SSCS_CLK_MHZ) / 1000)
`define SSCS_FETCH_RUN_CYC ((`SSCS_FETCH_RUN_NS * `SSCS_CLK_MHZ) / 1000)
`define SSCS_CNT_W 8
`define SSCS_NREG 8
`define SSCS_IDX_W 3
`define SSCS_ADDR_LINE_LEN 16'h0200
`define SSCS_ADDR_BLANK 16'h01f0
`define SSCS_ADDR_CLAMP 16'h2478
`define SSCS_ADDR_BANK 16'h2058
`define SSCS_ADDR_STATE 16'h4018
`define SSCS_ADDR_FBCTL 16'h4040
`define SSCS_ADDR_SRST 16'h4060
`define SSCS_ADDR_REV 16'h4000
`define SSCS_RST_LINE_LEN 16'h0578
`define SSCS_RST_BANK 16'h0300
`define SSCS_RST_CLAMP 16'h10b8
`define SSCS_CLS_ANY 2'h0
`define SSCS_CLS_CFG_IDLE 2'h1
`define SSCS_CLS_CFG_ONLY 2'h2
`define SSCS_ST_STANDBY 2'h0
`define SSCS_ST_CONFIG 2'h1
`define SSCS_ST_IDLE 2'h2
`define SSCS_ST_RUN 2'h3
`endif

/* File: sscs_slave.v */
// SPI configuration slave with shadow and active register memories
// Overview of operation
// - Block is only a slave; host master starts every transfer.
// - Interface active only while chip select low; high ends transfer.
// - Mode CPOL=1 CPHA=1: sample MOSI on rising SCK, idle high.
// - Read data may need a register-dependent fetch delay after address.
// - In configuration state fetch finishes within 1.5 us.
// - In capture_active_state state fetch may take up to 4.5 us.
// - When enabled, ready pin low during fetch, then high.
// - Ready feedback disabled after reset, enabled by control register.
// - Every SPI write lands in the shadow copy first.
// - Shadow copied to active at frame start or on allowed state entry.
// - SPI reads return the shadow copy, not the active value.
// - Some registers update while capture_active_state; others wait for configuration state, blanking for configuration or idle.
// - Line length written while capture_active_state applies after config and back.
// - Config-only class applies in configuration; unrestricted class any state.
// - In standby only state and soft-reset registers accept writes.
`timescale 1ns/1ps
`default_nettype none
`include "sscs_map.vh"
module sscs_slave #(
	parameter [15:0] REVISION_CODE = 16'h5a5a // Arbitrary value
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_ce,
	input wire i_chip_select_low,
	input wire i_sck,
	input wire i_mosi,
	input wire i_frame_start,
	output reg o_miso,
	output wire o_miso_oe,
	output reg o_read_ready_pin,
	output reg [1:0] o_sensor_state,
	output reg o_soft_reset,
	output reg [15:0] o_line_length,
	output reg [15:0] o_blanking,
	output reg [15:0] o_clamp,
	output reg [15:0] o_bank_select
);
	localparam [3:0] S_CMD = 4'h1;
	localparam [3:0] S_FETCH = 4'h2;
	localparam [3:0] S_DATA = 4'h4;
	localparam [3:0] S_DONE = 4'h8;
	// Shadow memory index map
	localparam [2:0] I_LL = 3'h0;
	localparam [2:0] I_BL = 3'h1;
	localparam [2:0] I_CL = 3'h2;
	localparam [2:0] I_BK = 3'h3;
	localparam [2:0] I_ST = 3'h4;
	localparam [2:0] I_FB = 3'h5;
	localparam [2:0] I_SR = 3'h6;
	localparam [2:0] I_RV = 3'h7;
	// Cycle counts are worked out as integers, then cut to the counter width on purpose
	localparam integer FETCH_CFG_I = `SSCS_FETCH_CFG_CYC;
	localparam integer FETCH_RUN_I = `SSCS_FETCH_RUN_CYC;
	localparam [7:0] FETCH_CFG = FETCH_CFG_I[7:0];
	localparam [7:0] FETCH_RUN = FETCH_RUN_I[7:0];

	// Address to index; bit 0 is the write flag, so it is ignored here
	function [3:0] decode;
		input [15:0] a;
		begin
			case ({a[15:1], 1'b0})
				`SSCS_ADDR_LINE_LEN: decode = {1'b1, I_LL};
				`SSCS_ADDR_BLANK: decode = {1'b1, I_BL};
				`SSCS_ADDR_CLAMP: decode = {1'b1, I_CL};
				`SSCS_ADDR_BANK: decode = {1'b1, I_BK};
				`SSCS_ADDR_STATE: decode = {1'b1, I_ST};
				`SSCS_ADDR_FBCTL: decode = {1'b1, I_FB};
				`SSCS_ADDR_SRST: decode = {1'b1, I_SR};
				`SSCS_ADDR_REV: decode = {1'b1, I_RV};
				default: decode = 4'h0;
			endcase
		end
	endfunction

	// Writability class of each index
	function [1:0] wclass;
		input [2:0] i;
		begin
			case (i)
				I_LL: wclass = `SSCS_CLS_CFG_ONLY;
				I_BL: wclass = `SSCS_CLS_CFG_IDLE;
				I_BK: wclass = `SSCS_CLS_CFG_ONLY;
				default: wclass = `SSCS_CLS_ANY;
			endcase
		end
	endfunction

	function allowed;
		input [2:0] i;
		input [1:0] st;
		begin
			case (wclass(i))
				`SSCS_CLS_CFG_ONLY: allowed = (st == `SSCS_ST_CONFIG);
				`SSCS_CLS_CFG_IDLE: allowed = (st == `SSCS_ST_CONFIG) ||
					(st == `SSCS_ST_IDLE);
				default: allowed = 1'b1;
			endcase
		end
	endfunction

	// Standby lets only the state and soft-reset words through; revision is read-only
	function accept_wr;
		input [3:0] d;
		input [1:0] st;
		begin
			if (!d[3] || d[2:0] == I_RV)
				accept_wr = 1'b0;
			else if (st == `SSCS_ST_STANDBY)
				accept_wr = (d[2:0] == I_ST) || (d[2:0] == I_SR);
			else
				accept_wr = 1'b1;
		end
	endfunction

	// Worst case of each state is waited out; revision is held locally and answers at once
	function [7:0] fetch_len;
		input [15:0] a;
		input [1:0] st;
		begin
			if (decode(a) == {1'b1, I_RV})
				fetch_len = 8'h1;
			else if (st == `SSCS_ST_RUN)
				fetch_len = FETCH_RUN;
			else
				fetch_len = FETCH_CFG;
		end
	endfunction

	// Unmapped addresses read as zero
	function [15:0] read_word;
		input [3:0] d;
		input [15:0] v;
		begin
			read_word = d[3] ? v : 16'h0;
		end
	endfunction

	// Pin synchronisers
	reg [1:0] cs_s;
	reg [1:0] sck_s;
	reg [1:0] mosi_s;
	reg sck_d;
	reg [15:0] shadow [0:7];
	reg [3:0] st_r;
	reg [4:0] bit_r;
	reg [15:0] sh_r;
	reg [15:0] addr_r;
	reg [7:0] cnt_r;
	reg [15:0] tx_r;
	reg [1:0] prev_state_r;
	integer k;
	wire active = ~cs_s[1];
	wire rise = active & sck_s[1] & ~sck_d;
	wire fall = active & ~sck_s[1] & sck_d;
	wire [15:0] sh_nxt = {sh_r[14:0], mosi_s[1]};
	wire [3:0] dec = decode(addr_r);
	wire is_write = addr_r[0];
	wire wr_ok = accept_wr(dec, o_sensor_state);
	// Ready feedback also lets the host see that the pin is meaningful only when enabled
	wire fb_en = shadow[I_FB][0];
	assign o_miso_oe = active;

	// Two flops on every pin; the second stage feeds logic, and SCK also goes through sck_d for edge detect
	always @(posedge i_clock) begin
		if (i_rst) begin
			cs_s <= 2'h3;
			sck_s <= 2'h3;
			mosi_s <= 2'h0;
			sck_d <= 1'b1;
		end else if (i_ce) begin
			cs_s <= {cs_s[0], i_chip_select_low};
			sck_s <= {sck_s[0], i_sck};
			mosi_s <= {mosi_s[0], i_mosi};
			sck_d <= sck_s[1];
		end
	end

	// Transfer engine; a half period of SCK must span more than the sync delay
	always @(posedge i_clock) begin
		if (i_rst) begin
			st_r <= S_CMD;
			bit_r <= 5'h0;
			sh_r <= 16'h0;
			addr_r <= 16'h0;
			cnt_r <= 8'h0;
			tx_r <= 16'h0;
			o_miso <= 1'b0;
			o_read_ready_pin <= 1'b0;
			for (k = 0; k < `SSCS_NREG; k = k + 1)
				shadow[k] <= 16'h0;
			shadow[I_LL] <= `SSCS_RST_LINE_LEN;
			shadow[I_CL] <= `SSCS_RST_CLAMP;
			shadow[I_BK] <= `SSCS_RST_BANK;
			shadow[I_ST] <= {14'h0, `SSCS_ST_CONFIG};
			shadow[I_RV] <= REVISION_CODE;
		end else if (i_ce) begin
			if (!active) begin
				st_r <= S_CMD;
				bit_r <= 5'h0;
				o_read_ready_pin <= 1'b0;
			end else begin
				case (st_r)
					S_CMD: begin
						if (rise) begin
							sh_r <= sh_nxt;
							bit_r <= bit_r + 5'h1;
							if (bit_r == 5'hf) begin
								addr_r <= sh_nxt;
								bit_r <= 5'h0;
								// Fetch time depends on the register and the state
								if (!sh_nxt[0]) begin
									st_r <= S_FETCH;
									cnt_r <= fetch_len(sh_nxt, o_sensor_state);
								end else
									st_r <= S_DATA;
							end
						end
					end
					S_FETCH: begin
						if (cnt_r > 8'h1)
							cnt_r <= cnt_r - 8'h1;
						else begin
							tx_r <= read_word(dec, shadow[dec[2:0]]);
							o_read_ready_pin <= fb_en;
							st_r <= S_DATA;
						end
					end
					S_DATA: begin
						if (!is_write && fall) begin
							o_miso <= tx_r[15];
							tx_r <= {tx_r[14:0], 1'b0};
						end
						if (rise) begin
							sh_r <= sh_nxt;
							bit_r <= bit_r + 5'h1;
							if (bit_r == 5'hf) begin
								st_r <= S_DONE;
								o_read_ready_pin <= 1'b0;
								// Writes go to shadow only, gated in standby
								if (is_write && wr_ok)
									shadow[dec[2:0]] <= sh_nxt;
							end
						end
					end
					S_DONE: st_r <= S_DONE;
					default: st_r <= S_CMD;
				endcase
			end
		end
	end

	// Frame start or any change of state opens a copy window
	wire apply = i_frame_start || (prev_state_r != o_sensor_state);

	// State and soft reset follow their shadow words one clock after a write
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_sensor_state <= `SSCS_ST_CONFIG;
			prev_state_r <= `SSCS_ST_CONFIG;
			o_soft_reset <= 1'b0;
		end else if (i_ce) begin
			o_sensor_state <= shadow[I_ST][1:0];
			o_soft_reset <= shadow[I_SR][0];
			prev_state_r <= o_sensor_state;
		end
	end

	// Active memory: the class of each word decides whether a window may take it
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_line_length <= `SSCS_RST_LINE_LEN;
			o_blanking <= 16'h0;
			o_clamp <= `SSCS_RST_CLAMP;
			o_bank_select <= `SSCS_RST_BANK;
		end else if (i_ce && apply) begin
			o_clamp <= shadow[I_CL];
			if (allowed(I_LL, o_sensor_state))
				o_line_length <= shadow[I_LL];
			if (allowed(I_BL, o_sensor_state))
				o_blanking <= shadow[I_BL];
			if (allowed(I_BK, o_sensor_state))
				o_bank_select <= shadow[I_BK];
		end
	end
endmodule // sscs_slave
`default_nettype wire

/* File: sscs_chk.sv */
// Port checker for the SPI configuration slave
`timescale 1ns/1ps
`default_nettype none
module sscs_chk (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_chip_select_low,
	input wire logic i_frame_start,
	input wire logic o_miso_oe,
	input wire logic o_read_ready_pin,
	input wire logic [1:0] o_sensor_state,
	input wire logic [15:0] o_line_length,
	input wire logic [15:0] o_blanking,
	input wire logic [15:0] o_clamp,
	input wire logic [15:0] o_bank_select
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic [1:0] st_r, st2_r;
	// State copies let a copy one edge after the state change still count
	wire cfg = o_sensor_state == 2'h1 || st_r == 2'h1;
	always_ff @(posedge i_clock) begin
		st_r <= o_sensor_state;
		st2_r <= st_r;
	end
	oe_on_a: assert property ($fell(i_chip_select_low) |-> ##[1:3] o_miso_oe)
		else $error("miso enable late");
	oe_off_a: assert property (i_chip_select_low [*4] |-> !o_miso_oe)
		else $error("miso enable while idle");
	rdy_idle_a: assert property (i_chip_select_low [*5] |-> !o_read_ready_pin)
		else $error("ready high while idle");
	rdy_rise_a: assert property ($rose(o_read_ready_pin) |-> !$past(i_chip_select_low, 8))
		else $error("ready outside transfer");
	clamp_upd_a: assert property ($changed(o_clamp) |-> $past(i_frame_start) ||
		$past(i_frame_start, 2) || st_r != o_sensor_state || st2_r != st_r)
		else $error("clamp applied without cause");
	len_cfg_a: assert property ($changed(o_line_length) |-> cfg)
		else $error("line length applied outside config");
	bank_cfg_a: assert property ($changed(o_bank_select) |-> cfg)
		else $error("bank applied outside config");
	blank_cls_a: assert property ($changed(o_blanking) |-> cfg || st_r == 2'h2)
		else $error("blanking applied while capture_active_state");
	cover property ($rose(o_read_ready_pin));
	cover property ($changed(o_line_length));
	cover property ($changed(o_clamp));
endmodule // sscs_chk
bind sscs_slave sscs_chk u_chk (.i_clock(i_clock), .i_rst(i_rst),
	.i_chip_select_low(i_chip_select_low), .i_frame_start(i_frame_start),
	.o_miso_oe(o_miso_oe), .o_read_ready_pin(o_read_ready_pin), .o_sensor_state(o_sensor_state),
	.o_line_length(o_line_length), .o_blanking(o_blanking), .o_clamp(o_clamp),
	.o_bank_select(o_bank_select));
`default_nettype wire

/* File: sscs_host.sv */
// Host SPI master model for the configuration slave
`timescale 1ns/1ps
`default_nettype none
module sscs_host (
	input wire logic i_clock,
	input wire logic i_miso,
	input wire logic i_read_ready_pin,
	output logic o_chip_select_low,
	output logic o_sck,
	output logic o_mosi,
	output logic [15:0] o_q,
	output logic o_qv
);
	initial begin
		o_chip_select_low = 1;
		o_sck = 1;
		o_mosi = 0;
		o_q = 0;
		o_qv = 0;
	end
	// Four system clocks a half period keep SCK on falling clock edges
	task automatic half;
		repeat (4) @(negedge i_clock);
	endtask
	// A wait of zero paces the read by the ready pin
	task automatic xfer(input logic [15:0] a, input logic [15:0] d, input int wt);
		logic [31:0] w;
		logic bad;
		w = {a, d};
		bad = wt == 0 && i_read_ready_pin;
		o_chip_select_low = 0;
		half();
		for (int i = 31; i >= 0; i--) begin
			if (i == 15 && !a[0]) begin
				for (int n = 0; n < (wt != 0 ? wt : 120) && !(wt == 0 && i_read_ready_pin); n++)
					@(negedge i_clock);
				bad = bad | ((wt == 0) != i_read_ready_pin);
			end
			o_sck = 0;
			o_mosi = w[i];
			half();
			o_sck = 1;
			o_q = {o_q[14:0], i_miso};
			half();
		end
		o_chip_select_low = 1;
		o_mosi = !o_mosi;
		o_q = bad ? 16'hxxxx : o_q;
		o_qv = !a[0];
		half();
		o_qv = 0;
	endtask
endmodule // sscs_host
`default_nettype wire

/* File: tb_sscs_slave.sv */
// Self-checking bench for the SPI configuration slave
`timescale 1ns/1ps
`default_nettype none
module tb_sscs_slave;
	logic i_clock = 0, i_rst = 1, i_frame_start = 0;
	wire cs, sck, mosi, miso, rdy, qv, oe, srst;
	wire [1:0] st;
	wire [15:0] len, blank, clamp, bank, q;
	logic [15:0] v, w;
	logic [15:0] expq[$];
	int mismatches = 0, check_count = 0, seed = 32'hc4f0;
	always #20 i_clock = ~i_clock;
	sscs_slave u_sscs_slave (.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1),
		.i_chip_select_low(cs), .i_sck(sck), .i_mosi(mosi), .i_frame_start(i_frame_start),
		.o_miso(miso), .o_miso_oe(oe), .o_read_ready_pin(rdy), .o_sensor_state(st),
		.o_soft_reset(srst), .o_line_length(len), .o_blanking(blank), .o_clamp(clamp),
		.o_bank_select(bank));
	// A released data line shows the inverse, so a late enable corrupts the read
	sscs_host u_sscs_host (.i_clock(i_clock), .i_miso(oe ? miso : ~miso), .i_read_ready_pin(rdy),
		.o_chip_select_low(cs), .o_sck(sck), .o_mosi(mosi), .o_q(q), .o_qv(qv));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		u_sscs_host.xfer(a | 16'h0001, d, 0);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input int wt);
		expq.push_back(e);
		u_sscs_host.xfer(a, 16'h0000, wt);
	endtask
	task automatic frame;
		i_frame_start = 1;
		@(negedge i_clock);
		i_frame_start = 0;
		repeat (2) @(negedge i_clock);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge qv) chk("read", expq.pop_front(), q);
	initial begin
		repeat (10) @(negedge i_clock);
		i_rst = 0;
		repeat (2) @(negedge i_clock);
		v = $random(seed);
		wr(16'h2479, v);
		wr(16'h01f1, ~v);
		wr(16'h2059, v ^ 16'h00ff);
		chk("clamp", 16'h10b8, clamp);
		rd(16'h2478, v, 40);
		frame();
		chk("clamp", v, clamp);
		chk("blank", ~v, blank);
		chk("bank", v ^ 16'h00ff, bank);
		wr(16'h4041, 16'h0001);
		rd(16'h2478, v, 0);
		wr(16'h4019, 16'h0003);
		chk("state", 16'h0003, {14'h0, st});
		w = $random(seed);
		wr(16'h0201, w);
		rd(16'h0200, w, 0);
		frame();
		chk("len", 16'h0578, len);
		wr(16'h4019, 16'h0001);
		wr(16'h4019, 16'h0003);
		chk("len", w, len);
		wr(16'h4019, 16'h0000);
		wr(16'h2479, w);
		rd(16'h2478, v, 0);
		chk("clamp", v, clamp);
		wr(16'h4061, 16'h0001);
		chk("srst", 16'h0001, {15'h0, srst});
		wr(16'h4001, 16'h1234);
		rd(16'h4000, 16'h5a5a, 0);
		tally_and_finish();
	end
	initial begin
		#1000000;
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_sscs_slave
`default_nettype wire
